// *** rtl/irq_prio_pkg.sv ***
// holds the shared constants and types of the interrupt priority word block
// assumes a 16-bit software register port and one 50 MHz clock domain
package irq_prio_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned DATA_W  = 16;   // register data width
  localparam int unsigned ADDR_W  = 4;    // register port address width
  localparam int unsigned LVL_W   = 3;    // one priority field
  localparam int unsigned NSRC    = 4;    // sources covered by the word
  localparam int unsigned FIELD_STRIDE = 4; // field spacing inside the word

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] PRIO_WORD_ADDR = 4'h0;   // priority_word_two
  localparam logic [3:0] STATUS_ADDR    = 4'h1;   // arbitration status

  // ****************************************************************
  // priority word layout and reset
  // ****************************************************************
  localparam int unsigned TIMER_THREE_LSB   = 0;
  localparam int unsigned SERIAL_ERROR_LSB  = 4;
  localparam int unsigned SERIAL_EVENT_LSB  = 8;
  localparam int unsigned UART_RECEIVE_LSB  = 12;
  localparam logic [15:0] PRIO_WORD_RESET   = 16'h4444;  // each field resets to level 4
  localparam logic [15:0] PRIO_WRITE_MASK   = 16'h7777;  // bits 15, 11, 7, 3 unimplemented

  // ****************************************************************
  // status word layout
  // ****************************************************************
  localparam int unsigned STAT_LEVEL_LSB    = 0;   // winning level, 3 bits
  localparam int unsigned STAT_INDEX_LSB    = 4;   // winning source index, 2 bits
  localparam int unsigned STAT_VALID_BIT    = 8;   // some source requests
  localparam int unsigned STAT_REQ_LSB      = 12;  // gated requests, 4 bits

  // ****************************************************************
  // level encodings
  // ****************************************************************
  localparam logic [2:0] LVL_OFF = 3'h0;  // source disabled
  localparam logic [2:0] LVL_MIN = 3'h1;  // lowest enabled level
  localparam logic [2:0] LVL_MAX = 3'h7;  // highest level

  typedef logic [2:0] level_t;
  typedef logic [1:0] src_index_t;

endpackage : irq_prio_pkg

// *** rtl/irq_priority_control_word.sv ***
// holds one interrupt priority word and gates/arbitrates its four sources
// assumes source flags come from logic on mclk; software uses the plain port
//
// Contract
// - uart receive level in bits 14-12, 111=level 7
// - level 7 highest; higher codes outrank lower
// - code 001 is level 1, all fields
// - code 000 disables the source entirely
// - serial event level in bits 10-8
`timescale 1ns/100ps
module irq_priority_control_word (
  input  wire logic                 mclk,                   // 50 MHz system clock
  input  wire logic                 rst_b,                  // async reset, active low
  input  wire logic [3:0]           reg_addr,               // register address
  input  wire logic [15:0]          reg_wdata,              // write data
  input  wire logic                 reg_wr,                 // write strobe
  input  wire logic                 reg_rd,                 // read strobe
  output logic [15:0]               reg_rdata,              // read data, cycle after strobe
  input  wire logic [3:0]           src_flag,               // raw source flags {uart,event,error,timer}
  output irq_prio_pkg::level_t      uart_receive_priority,  // field 14-12
  output irq_prio_pkg::level_t      serial_event_priority,  // field 10-8
  output irq_prio_pkg::level_t      serial_error_priority,  // field 6-4
  output irq_prio_pkg::level_t      timer_three_priority,   // field 2-0
  output logic [3:0]                src_request,            // gated requests
  output irq_prio_pkg::level_t      win_level,              // highest requesting level
  output irq_prio_pkg::src_index_t  win_index,              // its source
  output logic                      win_valid               // any request present
);
  import irq_prio_pkg::*;

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [15:0] priority_word_two;   // the priority word itself
  logic [15:0] next_word;           // masked write value
  logic [15:0] next_rdata;          // read mux result
  logic [15:0] status_word;         // arbitration snapshot
  logic [3:0]  enabled;             // field nonzero per source
  logic [3:0]  next_request;        // flags gated by enable

  prio_arb_if arb ();

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire wr_word = reg_wr && (reg_addr == PRIO_WORD_ADDR);   // write hits the word
  wire rd_word = reg_rd && (reg_addr == PRIO_WORD_ADDR);   // read of the word
  wire rd_stat = reg_rd && (reg_addr == STATUS_ADDR);      // read of status

  // unimplemented bits are dropped on the way in so they can never read back
  assign next_word = reg_wdata & PRIO_WRITE_MASK;

  // unmapped reads and idle cycles return zero
  assign next_rdata = rd_word ? (priority_word_two & PRIO_WRITE_MASK) :
                      rd_stat ? status_word : 16'h0000;

  // status packs the registered arbitration result
  assign status_word = {src_request, 3'h0, win_valid, 2'h0, win_index, 1'h0, win_level};

  // ****************************************************************
  // per-source field extraction and gating
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_src
      // field i sits at bit 4*i; index 0 is timer three, 3 is uart receive
      assign arb.level[i]    = priority_word_two[i*FIELD_STRIDE +: LVL_W];
      assign enabled[i]      = (arb.level[i] != LVL_OFF);
      // a zero field blocks the flag outright, whatever its state
      assign next_request[i] = src_flag[i] && enabled[i];
    end
  endgenerate

  assign arb.req = next_request;

  // picker ranks by numeric level, so 7 beats everything below it
  prio_pick u_pick (
    .bus (arb.pick)
  );

  // ****************************************************************
  // priority word register
  // ****************************************************************
  // writes land one cycle after the strobe; no side effects beyond storing
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      priority_word_two <= PRIO_WORD_RESET;
    end else if (wr_word) begin
      priority_word_two <= next_word;
    end
  end

  // ****************************************************************
  // read data register
  // ****************************************************************
  // data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // arbitration output registers
  // ****************************************************************
  // registering costs one cycle of latency but keeps outputs glitch free
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      src_request <= 4'h0;
      win_level   <= LVL_OFF;
      win_index   <= 2'h0;
      win_valid   <= 1'b0;
    end else begin
      src_request <= next_request;
      win_level   <= arb.win_level;
      win_index   <= arb.win_index;
      win_valid   <= arb.win_valid;
    end
  end

  // field outputs are slices of the word flops
  assign timer_three_priority  = priority_word_two[TIMER_THREE_LSB  +: LVL_W];
  assign serial_error_priority = priority_word_two[SERIAL_ERROR_LSB +: LVL_W];
  assign serial_event_priority = priority_word_two[SERIAL_EVENT_LSB +: LVL_W];
  assign uart_receive_priority = priority_word_two[UART_RECEIVE_LSB +: LVL_W];

  // ****************************************************************
  // checks
  // ****************************************************************
  // helper: a requesting source whose level beats the picked level
  logic [3:0] outranked;
  generate
    for (i = 0; i < NSRC; i++) begin : g_chk
      assign outranked[i] = arb.req[i] && (arb.level[i] > arb.win_level);
    end
  endgenerate

  a_uart_write_seven: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_word && (reg_wdata[14:12] == 3'b111)) |=> (uart_receive_priority == LVL_MAX))
    else $error("uart receive field did not take level 7");

  a_win_highest_level: assert property (@(posedge mclk) disable iff (!rst_b)
    (outranked == 4'h0) && (arb.win_valid == (arb.req != 4'h0)))
    else $error("picked level is not the highest requesting level");

  // a tie at level 7 goes to the lower index, so only a sole level 7 is checked here
  a_win_registered: assert property (@(posedge mclk) disable iff (!rst_b)
    (src_flag[3] && (uart_receive_priority == LVL_MAX) && (serial_event_priority != LVL_MAX)
      && (serial_error_priority != LVL_MAX) && (timer_three_priority != LVL_MAX))
      |=> (win_level == LVL_MAX && win_index == 2'h3))
    else $error("level 7 uart request did not win");

  a_level_one_request: assert property (@(posedge mclk) disable iff (!rst_b)
    (src_flag == 4'b0001 && timer_three_priority == LVL_MIN)
      |=> (win_valid && win_level == LVL_MIN && win_index == 2'h0))
    else $error("level 1 timer request not seen as level 1");

  a_disabled_no_request: assert property (@(posedge mclk) disable iff (!rst_b)
    ##1 ((src_request & ~$past(enabled)) == 4'h0))
    else $error("disabled source raised a request");

  a_event_field_write: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_word |=> (serial_event_priority == $past(reg_wdata[10:8])))
    else $error("serial event field did not store written value");

  a_reserved_read_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_word |=> ((reg_rdata & ~PRIO_WRITE_MASK) == 16'h0000)
      && (reg_rdata == $past(priority_word_two & PRIO_WRITE_MASK)))
    else $error("reserved bits read nonzero or word misread");

  a_read_one_cycle: assert property (@(posedge mclk) disable iff (!rst_b)
    (!reg_rd) |=> (reg_rdata == 16'h0000))
    else $error("read data outside the answer cycle");

  // ****************************************************************
  // further checks
  // ****************************************************************
  // these watch the outputs from the far side: field slices, the
  // registered answer and the read port (the word hold, reserved store,
  // pick and tie checks read the word flops and the picker bus), so a slip in
  // the gating or in the picker shows up even where the internal checks
  // above still agree with themselves.
  // a reset cuts every attempt short; the checks that reach back one
  // cycle start only from an edge out of reset, since the flops answer
  // their reset values there (zero, 4444 for the word) whatever the inputs were.

  // helper: a requesting source that ties the winner at a lower index
  logic [3:0] tie_lost;
  generate
    for (i = 0; i < NSRC; i++) begin : g_tie
      assign tie_lost[i] = arb.win_valid && arb.req[i] && (arb.level[i] == arb.win_level)
                           && (src_index_t'(i) < arb.win_index);
    end
  endgenerate

  // helper: nonzero fields seen through the field outputs, order {uart,event,error,timer}
  wire [3:0] field_live = {(uart_receive_priority != LVL_OFF), (serial_event_priority != LVL_OFF),
                           (serial_error_priority != LVL_OFF), (timer_three_priority != LVL_OFF)};

  // helper: a read that hits neither the word nor the status place
  wire rd_unmapped = reg_rd && (reg_addr != PRIO_WORD_ADDR) && (reg_addr != STATUS_ADDR);

  a_uart_field_write: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_word |=> (uart_receive_priority == $past(reg_wdata[14:12])))
    else $error("uart receive field did not store written value");

  a_error_field_write: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_word |=> (serial_error_priority == $past(reg_wdata[6:4])))
    else $error("serial error field did not store written value");

  a_timer_field_write: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_word |=> (timer_three_priority == $past(reg_wdata[2:0])))
    else $error("timer three field did not store written value");

  // nothing but a write to the word may move it, reads and status writes included
  a_word_hold_idle: assert property (@(posedge mclk) disable iff (!rst_b)
    (!wr_word) |=> $stable(priority_word_two))
    else $error("priority word changed without a write");

  a_reserved_store_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    ((priority_word_two & ~PRIO_WRITE_MASK) == 16'h0000))
    else $error("unimplemented bit stored as one");

  a_unmapped_read_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_unmapped |=> (reg_rdata == 16'h0000))
    else $error("unmapped read returned nonzero data");

  a_pick_matches_source: assert property (@(posedge mclk) disable iff (!rst_b)
    arb.win_valid |-> (arb.req[arb.win_index] && (arb.level[arb.win_index] == arb.win_level)))
    else $error("picked source does not hold the picked level");

  a_tie_lower_index: assert property (@(posedge mclk) disable iff (!rst_b)
    (tie_lost == 4'h0))
    else $error("tie at equal level went to the higher index");

  // the registered request must be last cycle's flag masked by last cycle's fields
  a_request_follows_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    rst_b |=> (src_request == ($past(src_flag) & $past(field_live))))
    else $error("gated request does not follow flag and field");

  a_zero_field_blocks: assert property (@(posedge mclk) disable iff (!rst_b)
    (src_flag[3] && (uart_receive_priority == LVL_OFF))
      |=> (!src_request[3] && !(win_valid && (win_index == 2'h3))))
    else $error("disabled uart receive source still requested");

  a_idle_answer_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    (!win_valid) |-> ((win_level == LVL_OFF) && (win_index == 2'h0)))
    else $error("answer not zero while nothing requests");

  // status is a snapshot of the registered answer at the read strobe edge
  a_status_read_pack: assert property (@(posedge mclk) disable iff (!rst_b)
    rd_stat |=> ((reg_rdata[STAT_LEVEL_LSB +: LVL_W] == $past(win_level))
      && (reg_rdata[STAT_INDEX_LSB +: 2] == $past(win_index))
      && (reg_rdata[STAT_VALID_BIT] == $past(win_valid))
      && (reg_rdata[STAT_REQ_LSB +: 4] == $past(src_request))))
    else $error("status read does not match the registered answer");

endmodule : irq_priority_control_word

// *** rtl/prio_arb_if.sv ***
// carries per-source levels and requests to the picker and its answer back
// assumes both ends sit in the same clock domain
`timescale 1ns/100ps
interface prio_arb_if;
  import irq_prio_pkg::*;
  level_t     level [NSRC];   // per-source priority level
  logic [3:0] req;            // per-source request, already gated
  level_t     win_level;      // highest requesting level, zero if none
  src_index_t win_index;      // source that holds it
  logic       win_valid;      // any request present

  modport owner (output level, output req, input win_level, input win_index, input win_valid);
  modport pick  (input level, input req, output win_level, output win_index, output win_valid);
endinterface : prio_arb_if

// *** rtl/prio_pick.sv ***
// combinational picker: finds the highest requesting level among the sources
// assumes requests reaching it are already gated by a nonzero level
`timescale 1ns/100ps
module prio_pick (
  prio_arb_if.pick bus
);
  import irq_prio_pkg::*;

  // ****************************************************************
  // ripple chain of best-so-far
  // ****************************************************************
  level_t     best_lvl [NSRC+1];  // best level after each stage
  src_index_t best_idx [NSRC+1];  // its source

  assign best_lvl[0] = LVL_OFF;
  assign best_idx[0] = 2'h0;

  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_stage
      // strict compare: on a tie the lower index keeps the win
      wire take = bus.req[i] && (bus.level[i] > best_lvl[i]);
      assign best_lvl[i+1] = take ? bus.level[i] : best_lvl[i];
      assign best_idx[i+1] = take ? src_index_t'(i) : best_idx[i];
    end
  endgenerate

  assign bus.win_level = best_lvl[NSRC];
  assign bus.win_index = best_idx[NSRC];
  assign bus.win_valid = (best_lvl[NSRC] != LVL_OFF);

endmodule : prio_pick

// *** tb/testbench.sv ***
// self-checking bench for the interrupt priority word block
// assumes the design and its package are compiled first, one 50 MHz clock
`timescale 1ns/100ps
module testbench;
  import irq_prio_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic        mclk;                   // system clock
  logic        rst_b;                  // async reset, active low
  logic [3:0]  reg_addr;               // register address
  logic [15:0] reg_wdata;              // write data
  logic        reg_wr;                 // write strobe
  logic        reg_rd;                 // read strobe
  logic [15:0] reg_rdata;              // read data
  logic [3:0]  src_flag;               // raw source flags
  level_t      uart_receive_priority;  // field outputs
  level_t      serial_event_priority;
  level_t      serial_error_priority;
  level_t      timer_three_priority;
  logic [3:0]  src_request;            // gated requests
  level_t      win_level;              // arbitration answer
  src_index_t  win_index;
  logic        win_valid;
  int          mismatches;             // failed comparisons
  int          tests_run;              // comparisons made

  irq_priority_control_word irq_priority_control_word_i (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_flag(src_flag),
    .uart_receive_priority(uart_receive_priority), .serial_event_priority(serial_event_priority),
    .serial_error_priority(serial_error_priority), .timer_three_priority(timer_three_priority),
    .src_request(src_request), .win_level(win_level), .win_index(win_index), .win_valid(win_valid)
  );

  // ****************************************************************
  // clock and helpers
  // ****************************************************************
  // free-running 20 ns clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // one comparison; zero-extension keeps narrow fields exact
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe, so sample there
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  // all four field outputs against one expected word
  task automatic fields(input logic [15:0] w);
    #1;
    chk({1'b0, uart_receive_priority, 1'b0, serial_event_priority,
         1'b0, serial_error_priority, 1'b0, timer_three_priority}, w);
  endtask : fields

  // flags go in at one edge, the answer is registered at the next
  task automatic arb(input logic [3:0] f, input logic [3:0] req, input logic [2:0] lvl,
                     input logic [1:0] idx);
    @(posedge mclk);
    src_flag <= f;
    @(posedge mclk);
    #1;
    chk({req, 1'b0, lvl, 2'h0, idx, 3'h0, |req}, {src_request, 1'b0, win_level, 2'h0, win_index, 3'h0, win_valid});
  endtask : arb

  // closing point for both normal end and watchdog
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // ****************************************************************
  // tests
  // ****************************************************************
  // watchdog: the sequence needs a few hundred cycles at most
  initial begin
    repeat (3000) @(posedge mclk);
    mismatches++;
    end_sim();
  end

  // main sequence
  initial begin
    mismatches = 0;
    tests_run  = 0;
    rst_b = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000;
    reg_wr = 1'b0; reg_rd = 1'b0; src_flag = 4'h0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    fields(PRIO_WORD_RESET);
    rd(PRIO_WORD_ADDR, PRIO_WORD_RESET);
    wr(PRIO_WORD_ADDR, 16'hFFFF);
    fields(16'h7777);
    rd(PRIO_WORD_ADDR, 16'h7777);
    // every code in every field, spare bits written as ones; ties go to index 0
    for (int c = 0; c < 8; c++) begin
      wr(PRIO_WORD_ADDR, {4{1'b1, 3'(c)}});
      fields({4{1'b0, 3'(c)}});
      arb(4'hF, (c == 0) ? 4'h0 : 4'hF, 3'(c), 2'h0);
      rd(PRIO_WORD_ADDR, {4{1'b0, 3'(c)}});
    end
    // distinct levels: the higher code wins whatever its index
    wr(PRIO_WORD_ADDR, 16'h7351);
    arb(4'hF, 4'hF, 3'h7, 2'h3);
    rd(STATUS_ADDR, 16'hF137);
    arb(4'h7, 4'h7, 3'h5, 2'h1);
    arb(4'h5, 4'h5, 3'h3, 2'h2);
    arb(4'h1, 4'h1, 3'h1, 2'h0);
    arb(4'h0, 4'h0, 3'h0, 2'h0);
    // a disabled source never requests, even beside live ones
    wr(PRIO_WORD_ADDR, 16'h0351);
    arb(4'h8, 4'h0, 3'h0, 2'h0);
    arb(4'h9, 4'h1, 3'h1, 2'h0);
    // unmapped and read-only places leave the word alone
    wr(4'h2, 16'hFFFF);
    rd(4'h2, 16'h0000);
    wr(STATUS_ADDR, 16'hFFFF);
    rd(PRIO_WORD_ADDR, 16'h0351);
    // a reset in mid-run brings every field back to level 4
    @(posedge mclk);
    src_flag <= 4'h0;
    rst_b    <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b    <= 1'b1;
    fields(PRIO_WORD_RESET);
    rd(PRIO_WORD_ADDR, PRIO_WORD_RESET);
    arb(4'h1, 4'h1, 3'h4, 2'h0);
    end_sim();
  end
endmodule : testbench
